/* rtl/pdr_pkg.sv */
package pdr_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_WORD      = 4'h8;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam int          CTRL_RELAY_BIT = 0;
  localparam int          CTRL_CCIS_BIT  = 1;
  localparam int          STAT_LOCK_BIT  = 0;
  localparam int          STAT_PD_BIT    = 1;
  localparam int          STAT_A_BIT     = 2;
  localparam int          STAT_B_BIT     = 3;
  localparam int          WORD_SAMP_LSB  = 16;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint unsigned CLK_FREQ_HZ  = 100_000_000;
  localparam longint unsigned CONV_FREQ_HZ = 1_024_000;
  localparam longint unsigned FILT_FREQ_HZ = 128_000;
  localparam int unsigned     LOCK_TIME_MS = 20;
  localparam int unsigned     LOCK_MAX_MS  = 90;
  localparam int unsigned     LOSS_TIME_US = 250;
  localparam int unsigned     LOCK_CYCLES  = LOCK_TIME_MS * int'(CLK_FREQ_HZ / 1000);
  localparam int unsigned     LOSS_CYCLES  = LOSS_TIME_US * int'(CLK_FREQ_HZ / 1_000_000);
  localparam logic [31:0]     NCO_STEP     =
    32'((CONV_FREQ_HZ * (64'h1 << 32)) / CLK_FREQ_HZ);
  localparam int              FILT_DIV     = int'(CONV_FREQ_HZ / FILT_FREQ_HZ);
  localparam int              FILT_CNT_W   = $clog2(FILT_DIV);

  // ****************************************************************
  // word format
  // ****************************************************************
  localparam int           WORD_BITS = 8;
  localparam logic [15:0]  MU_BIAS   = 16'h0084;

endpackage

/* rtl/pdr_lock_detect.sv */
`timescale 1ns/10ps
module pdr_lock_detect #(
  parameter int unsigned LOCK_CYCLES = pdr_pkg::LOCK_CYCLES,
  parameter int unsigned LOSS_CYCLES = pdr_pkg::LOSS_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic strobe_rise,
  output logic      locked
);

  logic [31:0] gap_q;
  logic [31:0] lock_q;
  logic        present_q;
  logic        locked_q;

  // ****************************************************************
  // strobe presence
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_q     <= 32'h0000_0000;
      present_q <= 1'b0;
    end
    else if (strobe_rise)
    begin
      gap_q     <= 32'h0000_0000;
      present_q <= 1'b1;
    end
    else if (gap_q >= LOSS_CYCLES - 1)
      present_q <= 1'b0;
    else
      gap_q <= gap_q + 32'h0000_0001;
  end

  // ****************************************************************
  // lock-up interval
  // ****************************************************************
  // outputs stay idle for the whole interval after strobes resume
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_q   <= 32'h0000_0000;
      locked_q <= 1'b0;
    end
    else if (!present_q)
    begin
      lock_q   <= 32'h0000_0000;
      locked_q <= 1'b0;
    end
    else if (lock_q >= LOCK_CYCLES - 1)
      locked_q <= 1'b1;
    else
      lock_q <= lock_q + 32'h0000_0001;
  end

  assign locked = locked_q;

endmodule

/* rtl/pdr_receive.sv */
`timescale 1ns/10ps
// How it works
// - timing locks to strobe; 128 kHz filter and 1.024 MHz converter clocks
// - missing strobes drop lock and put the block into power-down
// - power-down makes amplifier high impedance and both signaling outputs inactive
// - after strobes resume, outputs stay idle for the lock-up interval
// - strobe rising edge starts a new word, one bit per shift clock
// - full word is mu-255 decoded and handed to sample-and-hold
// - select rising edge latches received eighth bit onto output A
// - select falling edge latches received signaling bit onto output B
// - outside common-channel mode, signaling latches change only right after their select transition or on loss of lock
// - common-channel option latches A at bit time 1, B at bit 8
// - each bit is sampled on a falling shift clock after strobe rose
// - relay polarity option inverts both signaling outputs
module pdr_receive #(
  parameter int unsigned LOCK_CYCLES = pdr_pkg::LOCK_CYCLES,
  parameter int unsigned LOSS_CYCLES = pdr_pkg::LOSS_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        shift_clk,
  input  wire logic        strobe,
  input  wire logic        pcm_in,
  input  wire logic        sig_select,
  input  wire logic        sig_ab_in,
  output logic             sig_a_out,
  output logic             sig_b_out,
  output logic             amp_hiz,
  output logic             power_down,
  output logic             conv_clk,
  output logic             filt_clk,
  output logic [15:0]      dac_sample,
  output logic             dac_load
);

  localparam int FW = pdr_pkg::FILT_CNT_W;

  logic        locked;
  logic        sck_q;
  logic        str_q;
  logic        sel_q;
  logic        sck_fall;
  logic        str_rise;
  logic        sel_rise;
  logic        sel_fall;
  logic        rx_active_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  last_word_q;
  logic        word_done_q;
  logic        word_end;
  logic        a_q;
  logic        b_q;
  logic [15:0] sample_q;
  logic        load_q;
  logic [31:0] nco_q;
  logic        conv_q;
  logic [FW-1:0] filt_cnt_q;
  logic [31:0] ctrl_q;
  logic        relay_mode;
  logic        ccis_mode;
  logic [3:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // ****************************************************************
  // mu-255 expansion to signed linear
  // ****************************************************************
  function automatic logic [15:0] mu_decode(input logic [7:0] w);
    logic [7:0]  u;
    logic [15:0] t;
    logic [15:0] mag;
    u   = ~w;
    t   = (16'({u[3:0], 3'h0}) + pdr_pkg::MU_BIAS) << u[6:4];
    mag = t - pdr_pkg::MU_BIAS;
    return u[7] ? 16'(-mag) : mag;
  endfunction

  // ****************************************************************
  // lock detector
  // ****************************************************************
  pdr_lock_detect #(
    .LOCK_CYCLES (LOCK_CYCLES),
    .LOSS_CYCLES (LOSS_CYCLES)
  ) u_lock (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .strobe_rise (str_rise),
    .locked      (locked)
  );

  assign relay_mode = ctrl_q[pdr_pkg::CTRL_RELAY_BIT];
  assign ccis_mode  = ctrl_q[pdr_pkg::CTRL_CCIS_BIT];

  // ****************************************************************
  // edge detection
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_q <= 1'b0;
      str_q <= 1'b0;
    end
    else
    begin
      sck_q <= shift_clk;
      str_q <= strobe;
    end
  end

  // select is only looked at on shift edges, so glitches between edges are ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sel_q <= 1'b0;
    else if (sck_fall)
      sel_q <= sig_select;
  end

  assign sck_fall = sck_q & ~shift_clk;
  assign str_rise = ~str_q & strobe;
  assign sel_rise = sck_fall & sig_select & ~sel_q;
  assign sel_fall = sck_fall & ~sig_select & sel_q;
  assign word_end = sck_fall & rx_active_q & (bit_cnt_q == 3'h7);

  // ****************************************************************
  // serial word input
  // ****************************************************************
  // a strobe edge in the same cycle as a shift edge restarts the word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_active_q <= 1'b0;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 8'h00;
    end
    else if (str_rise)
    begin
      rx_active_q <= locked;
      bit_cnt_q   <= 3'h0;
    end
    else if (sck_fall && rx_active_q)
    begin
      shift_q   <= {shift_q[6:0], pcm_in};
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7)
        rx_active_q <= 1'b0;
    end
    else if (!locked)
      rx_active_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_word_q <= 8'hFF;
      word_done_q <= 1'b0;
    end
    else
    begin
      word_done_q <= word_end & locked;
      if (word_end && locked)
        last_word_q <= {shift_q[6:0], pcm_in};
    end
  end

  // ****************************************************************
  // decoder handoff
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_q <= 16'h0000;
      load_q   <= 1'b0;
    end
    else
    begin
      load_q <= word_done_q;
      if (word_done_q)
        sample_q <= mu_decode(last_word_q);
    end
  end

  // ****************************************************************
  // signaling latches
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else if (!locked)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else if (ccis_mode)
    begin
      if (sck_fall && rx_active_q && bit_cnt_q == 3'h0)
        a_q <= sig_ab_in;
      if (word_end)
        b_q <= sig_ab_in;
    end
    else
    begin
      if (sel_rise)
        a_q <= last_word_q[0];
      if (sel_fall)
        b_q <= last_word_q[0];
    end
  end

  assign sig_a_out  = locked & (a_q ^ relay_mode);
  assign sig_b_out  = locked & (b_q ^ relay_mode);
  assign amp_hiz    = ~locked;
  assign power_down = ~locked;
  assign dac_sample = sample_q;
  assign dac_load   = load_q;

  // ****************************************************************
  // converter and filter clocks
  // ****************************************************************
  // phase restarts on each strobe so both clocks track the frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nco_q      <= 32'h0000_0000;
      conv_q     <= 1'b0;
      filt_cnt_q <= '0;
    end
    else if (!locked || str_rise)
    begin
      nco_q      <= 32'h0000_0000;
      conv_q     <= 1'b0;
      filt_cnt_q <= '0;
    end
    else
    begin
      nco_q  <= nco_q + pdr_pkg::NCO_STEP;
      conv_q <= nco_q[31];
      if (nco_q[31] && !conv_q)
        filt_cnt_q <= filt_cnt_q + FW'(1);
    end
  end

  assign conv_clk = conv_q;
  assign filt_clk = filt_cnt_q[FW-1];

  // ****************************************************************
  // axi4-lite write
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (aw_have_q && w_have_q && !bvalid_q)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (aw_have_q && w_have_q && !bvalid_q)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= pdr_pkg::CTRL_RESET;
      bvalid_q <= 1'b0;
      bresp_q  <= pdr_pkg::RESP_OKAY;
    end
    else if (aw_have_q && w_have_q && !bvalid_q)
    begin
      bvalid_q <= 1'b1;
      if (awaddr_q[3:2] == pdr_pkg::ADDR_CTRL[3:2])
      begin
        bresp_q <= pdr_pkg::RESP_OKAY;
        if (wstrb_q[0])
          ctrl_q[7:0] <= wdata_q[7:0] & 8'h03;
      end
      else if (awaddr_q[3:2] == pdr_pkg::ADDR_STATUS[3:2] ||
               awaddr_q[3:2] == pdr_pkg::ADDR_WORD[3:2])
        bresp_q <= pdr_pkg::RESP_OKAY;
      else
        bresp_q <= pdr_pkg::RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready  = ~w_have_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ****************************************************************
  // axi4-lite read
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= pdr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= pdr_pkg::RESP_OKAY;
      if (s_axi_araddr[3:2] == pdr_pkg::ADDR_CTRL[3:2])
        rdata_q <= ctrl_q;
      else if (s_axi_araddr[3:2] == pdr_pkg::ADDR_STATUS[3:2])
        rdata_q <= {28'h0000000, sig_b_out, sig_a_out, ~locked, locked};
      else if (s_axi_araddr[3:2] == pdr_pkg::ADDR_WORD[3:2])
        rdata_q <= {sample_q, 8'h00, last_word_q};
      else
      begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= pdr_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_word_end;
    word_end && locked;
  endsequence

  sequence s_handoff;
    word_done_q ##1 load_q;
  endsequence

  a_power_down_idle: assert property (!locked |-> amp_hiz && !sig_a_out && !sig_b_out)
    else $error("outputs active while unlocked");
  a_word_start: assert property (str_rise && locked |=> rx_active_q && bit_cnt_q == 3'h0)
    else $error("word not started on strobe rise");
  a_bit_sample: assert property (sck_fall && rx_active_q && !str_rise |=>
                                 shift_q[0] == $past(pcm_in))
    else $error("serial bit not sampled");
  a_decode_load: assert property (s_word_end |-> ##1 s_handoff ##0
                                  sample_q == mu_decode(last_word_q))
    else $error("decoded sample not loaded");
  a_unlocked_drop: assert property (word_end && !locked |=> !word_done_q ##1 !load_q)
    else $error("frame accepted before lock");
  a_sel_rise_a: assert property (locked && !ccis_mode && sel_rise |=>
                                 a_q == $past(last_word_q[0]))
    else $error("A not latched on select rise");
  a_sel_fall_b: assert property (locked && !ccis_mode && sel_fall |=>
                                 b_q == $past(last_word_q[0]))
    else $error("B not latched on select fall");
  a_sig_hold: assert property (locked && !ccis_mode && !sel_rise && !sel_fall &&
                               !$past(ctrl_q[1]) |=> $stable(a_q) && $stable(b_q))
    else $error("signaling changed without select edge");
  a_ccis_a_bit: assert property (locked && ccis_mode && sck_fall && rx_active_q &&
                                 bit_cnt_q == 3'h0 |=> a_q == $past(sig_ab_in))
    else $error("common-channel A bit not latched");
  // flipping the polarity option with the latches still must flip both pins
  a_polarity_out: assert property (locked && $past(locked) && $changed(relay_mode) &&
                                   $stable(a_q) && $stable(b_q) |->
                                   sig_a_out != $past(sig_a_out) &&
                                   sig_b_out != $past(sig_b_out))
    else $error("signaling polarity wrong");
  a_clock_phase: assert property (locked && str_rise |=> nco_q == 32'h0 && !conv_q)
    else $error("clock phase not restarted by strobe");
  // unlocked cycles counted apart from the detector, so an early lock is caught
  logic [31:0] unlock_cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || locked)
      unlock_cnt_q <= 32'h0000_0000;
    else if (unlock_cnt_q < LOCK_CYCLES)
      unlock_cnt_q <= unlock_cnt_q + 32'h0000_0001;
  end

  a_lock_release: assert property ($rose(locked) |-> unlock_cnt_q >= LOCK_CYCLES)
    else $error("lock before lock-up interval");

endmodule

/* test/pdr_highway_model.sv */
`timescale 1ns/10ps
// ****************************************************************
// highway model: strobe, shift clock, serial word, signaling
// ****************************************************************
module pdr_highway_model #(
  parameter int FRAME = 1000
) (
  input  wire logic       aclk,
  input  wire logic       run,
  input  wire logic [7:0] word,
  input  wire logic       sel,
  input  wire logic       a_bit,
  input  wire logic       b_bit,
  output logic            strobe,
  output logic            shift_clk,
  output logic            pcm_in,
  output logic            sig_select,
  output logic            sig_ab_in,
  output int              frames
);
  int         cnt = 0;
  int         ph;
  logic       act = 1'b0;
  logic [7:0] w_q;
  logic       a_q;
  logic       b_q;

  initial
  begin
    strobe = 1'b0;
    shift_clk = 1'b0;
    pcm_in = 1'b0;
    sig_select = 1'b0;
    sig_ab_in = 1'b0;
    frames = 0;
  end

  // data moves in mid high phase, so only a falling-edge sample sees the bit
  always @(posedge aclk)
  begin
    ph = cnt - 1;
    cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
    if (cnt == 0 && run)
    begin
      act <= 1'b1;
      strobe <= 1'b1;
      w_q <= word;
      a_q <= a_bit;
      b_q <= b_bit;
      sig_select <= sel;
    end
    else if (act && ph >= 0 && ph < 64)
    begin
      shift_clk <= (ph % 8) < 4;
      if (ph % 8 == 2)
      begin
        pcm_in <= w_q[7 - ph / 8];
        sig_ab_in <= (ph < 8) ? a_q : b_q;
      end
    end
    else
    begin
      // released lines toggle instead of keeping the last bit
      shift_clk <= 1'b0;
      pcm_in <= ~pcm_in;
      sig_ab_in <= ~sig_ab_in;
      strobe <= 1'b0;
      if (act)
        frames <= frames + 1;
      act <= 1'b0;
    end
  end
endmodule

/* test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam int LOCK  = 3000;
  localparam int LOSS  = 2500;
  localparam int FRAME = 1000;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        shift_clk, strobe, pcm_in, sig_select, sig_ab_in, dac_load;
  logic        sig_a_out, sig_b_out, amp_hiz, power_down, conv_clk, filt_clk;
  logic [15:0] dac_sample, last_s = 16'h0;
  logic [7:0]  word_r = 8'h0;
  logic        run = 1'b0, sel_r = 1'b0, a_r = 1'b0, b_r = 1'b0;
  logic        conv_p = 1'b0, filt_p = 1'b0;
  int          frames, fails = 0, checks_done = 0, loads = 0, new_loads;
  int          conv_n = 0, filt_n = 0;

  pdr_receive #(.LOCK_CYCLES(LOCK), .LOSS_CYCLES(LOSS)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shift_clk, .strobe, .pcm_in,
    .sig_select, .sig_ab_in, .sig_a_out, .sig_b_out, .amp_hiz, .power_down,
    .conv_clk, .filt_clk, .dac_sample, .dac_load
  );
  pdr_highway_model #(.FRAME(FRAME)) hw (
    .aclk, .run, .word(word_r), .sel(sel_r), .a_bit(a_r), .b_bit(b_r), .strobe,
    .shift_clk, .pcm_in, .sig_select, .sig_ab_in, .frames
  );

  always #5 aclk = ~aclk;

  always @(negedge aclk)
  begin
    if (dac_load === 1'b1)
    begin
      loads <= loads + 1;
      last_s <= dac_sample;
    end
    conv_n <= conv_n + int'(conv_clk & !conv_p);
    filt_n <= filt_n + int'(filt_clk & !filt_p);
    conv_p <= conv_clk;
    filt_p <= filt_clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic sig(input logic a, input logic b);
    @(negedge aclk);
    chk("sig_a_out", a, sig_a_out);
    chk("sig_b_out", b, sig_b_out);
  endtask

  // handshakes judged at the negedge, so the edge that takes them is never raced
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, ta, tw, tk;
    int   n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50)
    begin
      @(negedge aclk);
      ta = aw & s_axi_awready;
      tw = w & s_axi_wready;
      tk = !aw & !w & s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (ta)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (tw)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (tk)
      begin
        s_axi_bready <= 1'b0;
        n = 99;
      end
    end
    chk("write_done", 32'h1, n == 99);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, ta, tk;
    int   n;
    ar = 1'b1;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50)
    begin
      @(negedge aclk);
      ta = ar & s_axi_arready;
      tk = !ar & s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ta)
      begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (tk)
      begin
        s_axi_rready <= 1'b0;
        n = 99;
      end
    end
    chk("read_done", 32'h1, n == 99);
  endtask

  task automatic next_frame;
    int f, n;
    f = frames;
    n = 0;
    while (frames == f && n < 2 * FRAME)
    begin
      @(negedge aclk);
      n++;
    end
    chk("frame_done", 32'h1, n < 2 * FRAME);
  endtask

  task automatic frame(input logic [7:0] w, input logic s, input logic a, input logic b);
    int l;
    next_frame;
    @(posedge aclk);
    word_r <= w;
    sel_r <= s;
    a_r <= a;
    b_r <= b;
    l = loads;
    next_frame;
    new_loads = loads - l;
  endtask

  task automatic wait_pd(input logic v, input int lim);
    int n;
    n = 0;
    while (power_down !== v && n < lim)
    begin
      @(negedge aclk);
      n++;
    end
    chk("power_down", v, power_down);
  endtask

  function automatic logic [15:0] mu(input logic [7:0] w);
    logic [7:0]  u;
    logic [15:0] t;
    u = ~w;
    t = ({9'h000, u[3:0], 3'h0} + pdr_pkg::MU_BIAS) << u[6:4];
    return u[7] ? pdr_pkg::MU_BIAS - t : t - pdr_pkg::MU_BIAS;
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    @(negedge aclk);
    chk("amp_hiz", 32'h1, amp_hiz);
    sig(1'b0, 1'b0);
    axi_rd(pdr_pkg::ADDR_CTRL, d, r);
    chk("ctrl_reset", pdr_pkg::CTRL_RESET, d);
    axi_rd(pdr_pkg::ADDR_STATUS, d, r);
    chk("status_reset", 32'h0000_0002, d);
    $display("t_reset done");
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(pdr_pkg::ADDR_CTRL, 32'hFFFF_FFFF, r);
    chk("ctrl_bresp", pdr_pkg::RESP_OKAY, r);
    axi_rd(pdr_pkg::ADDR_CTRL, d, r);
    chk("ctrl_mask", 32'h0000_0003, d);
    axi_wr(pdr_pkg::ADDR_CTRL, 32'h0000_0000, r);
    axi_wr(4'hC, 32'h0000_0001, r);
    chk("unmapped_bresp", pdr_pkg::RESP_SLVERR, r);
    axi_rd(4'hC, d, r);
    chk("unmapped_rresp", pdr_pkg::RESP_SLVERR, r);
    chk("unmapped_rdata", 32'h0000_0000, d);
    axi_wr(pdr_pkg::ADDR_STATUS, 32'hFFFF_FFFF, r);
    chk("status_bresp", pdr_pkg::RESP_OKAY, r);
    axi_rd(pdr_pkg::ADDR_STATUS, d, r);
    chk("status_ro", 32'h0000_0002, d);
    $display("t_regs done");
  endtask

  task automatic t_lock;
    int c, f;
    @(posedge aclk);
    run <= 1'b1;
    repeat (LOCK / 2) @(negedge aclk);
    chk("pd_early", 32'h1, power_down);
    sig(1'b0, 1'b0);
    chk("loads_early", 32'h0, loads);
    wait_pd(1'b0, 2 * LOCK);
    chk("amp_on", 32'h0, amp_hiz);
    next_frame;
    c = conv_n;
    f = filt_n;
    next_frame;
    chk("conv_rises", 32'h1, (conv_n - c) inside {[10:11]});
    chk("filt_rises", 32'h1, (filt_n - f) inside {[1:2]});
    $display("t_lock done");
  endtask

  task automatic t_words;
    logic [7:0]  tbl [5] = '{8'hFF, 8'h00, 8'h80, 8'h7F, 8'hA5};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (tbl[i])
    begin
      frame(tbl[i], 1'b0, 1'b0, 1'b0);
      chk("loads", 32'h1, new_loads);
      chk("dac_sample", mu(tbl[i]), last_s);
      axi_rd(pdr_pkg::ADDR_WORD, d, r);
      chk("word_reg", {mu(tbl[i]), 8'h00, tbl[i]}, d);
    end
    $display("t_words done");
  endtask

  task automatic t_robbed;
    logic [31:0] d;
    logic [1:0]  r;
    frame(8'h01, 1'b0, 1'b0, 1'b0);
    frame(8'h00, 1'b1, 1'b0, 1'b0);
    sig(1'b1, 1'b0);
    frame(8'h01, 1'b1, 1'b0, 1'b0);
    sig(1'b1, 1'b0);
    frame(8'h00, 1'b0, 1'b0, 1'b0);
    sig(1'b1, 1'b1);
    axi_wr(pdr_pkg::ADDR_CTRL, 32'h0000_0001, r);
    sig(1'b0, 1'b0);
    axi_rd(pdr_pkg::ADDR_STATUS, d, r);
    chk("status_relay", 32'h0000_0001, d);
    frame(8'h00, 1'b1, 1'b0, 1'b0);
    sig(1'b1, 1'b0);
    axi_wr(pdr_pkg::ADDR_CTRL, 32'h0000_0000, r);
    $display("t_robbed done");
  endtask

  task automatic t_ccis;
    logic [1:0] r;
    axi_wr(pdr_pkg::ADDR_CTRL, 32'h0000_0002, r);
    frame(8'h55, 1'b1, 1'b1, 1'b0);
    sig(1'b1, 1'b0);
    frame(8'h55, 1'b1, 1'b0, 1'b1);
    sig(1'b0, 1'b1);
    $display("t_ccis done");
  endtask

  task automatic t_loss;
    logic [31:0] d;
    logic [1:0]  r;
    int          l;
    @(posedge aclk);
    run <= 1'b0;
    wait_pd(1'b1, LOSS + 2 * FRAME);
    chk("amp_hiz_pd", 32'h1, amp_hiz);
    sig(1'b0, 1'b0);
    axi_rd(pdr_pkg::ADDR_STATUS, d, r);
    chk("status_pd", 32'h0000_0002, d);
    @(posedge aclk);
    run <= 1'b1;
    l = loads;
    repeat (LOCK / 2) @(negedge aclk);
    chk("pd_relock", 32'h1, power_down);
    sig(1'b0, 1'b0);
    chk("loads_relock", l, loads);
    wait_pd(1'b0, 2 * LOCK);
    $display("t_loss done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #800000;
    fails++;
    $display("[FAIL] watchdog expected done seen timeout");
    stop_test;
  end

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_regs;
    t_lock;
    t_words;
    t_robbed;
    t_ccis;
    t_loss;
    stop_test;
  end
endmodule
